// *** verilog/nfx_cfg.svh ***
`ifndef NFX_CFG_SVH
`define NFX_CFG_SVH
`define NFX_PC_W 12
`define NFX_PC_RST 12'h000
`define NFX_NIB_RST 4'h0
`define NFX_FLAGS_RST 16'h0000
`define NFX_OP_SWAP_H0 8'hf8
`define NFX_OP_SWAP_H1 8'hfc
`define NFX_OP_SWAP_L0 8'hf9
`define NFX_OP_SWAP_L1 8'hfd
`define NFX_OP_INDIRECT_PAGE_JUMP_OP 8'hfa
`define NFX_OP_RT 8'h62
`define NFX_OP_RTI 8'h22
`define NFX_HI_SETF 4'h5
`define NFX_HI_CLRF 4'h1
`define NFX_HI_CZP 4'hb
`define NFX_HI_JMP 5'h0d
`define NFX_HI_CAL 5'h05
`define NFX_HI_BAT 6'h1c
`endif

// *** verilog/nfx_pkg.sv ***
package nfx_pkg;
  // Working registers that the exchange opcodes touch
  typedef struct packed {
    logic [3:0] pointer_high_nibble;
    logic [3:0] pointer_low_nibble;
    logic [3:0] alt_high_reg0;
    logic [3:0] alt_high_reg1;
    logic [3:0] alt_low_reg0;
    logic [3:0] alt_low_reg1;
  } nfx_wregs_s;

  // Stack request towards the external stack storage
  typedef struct packed {
    logic push;
    logic pop;
    logic [11:0] push_pc;
  } nfx_stack_s;

  typedef enum logic [1:0] {
    NFX_FETCH,
    NFX_OPERAND,
    NFX_WAIT1,
    NFX_WAIT2
  } nfx_state_e;
endpackage

// *** verilog/nfx_core.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "nfx_cfg.svh"
module nfx_core
  import nfx_pkg::*;
#(
  parameter int PC_W = `NFX_PC_W
) (
  input wire logic clk,
  input wire logic rst,
  output logic [PC_W-1:0] rom_addr,
  input wire logic [7:0] rom_data,
  input wire logic [3:0] accumulator_nibble,
  input wire logic [3:0] ext_nibble,
  input wire logic [PC_W-1:0] stack_top,
  input wire logic saved_carry_flag,
  input wire logic saved_zero_flag,
  output nfx_stack_s stack_req,
  output nfx_wregs_s wregs,
  output logic [15:0] flags,
  output logic zero_flag,
  output logic carry_flag,
  output logic instr_done
);

  nfx_state_e state_q, state_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic [7:0] op_q, op_d;
  nfx_wregs_s wr_q, wr_d;
  logic [15:0] fl_q, fl_d;
  logic zf_q, zf_d, cf_q, cf_d;
  nfx_stack_s stk_q, stk_d;
  logic done_q, done_d;
  logic [15:0] fl_clr;
  logic [PC_W-1:0] op_pc;

  // Timing in short:
  //   one-byte ops act on the edge that decodes them
  //   two-byte ops read the operand on the next edge
  //   page jump holds the PC for two edges, lands on the third
  // instr_done rises the cycle after the last edge of each op.
  // The stack storage is outside; only push/pop pulses and the
  // value to push leave here, and stack_top is read as it stands.
  // No stall input: the ROM must answer within the same cycle,
  // because the byte at rom_addr is decoded on every fetch and operand edge.
  // Unknown opcodes fall through as one-byte no-ops, so a stray
  // byte never wedges the sequencer.
  // Jump and branch targets take their page and bank from the
  // opcode's own address, not from the already-advanced PC, so a
  // two-byte op that straddles a page keeps its own page.
  // Trade-off: swap and flag ops update in one edge with no
  // bypass, which is fine since each op sees settled state.

  // Advance the program counter by a small step
  function automatic logic [PC_W-1:0] pc_add(input logic [PC_W-1:0] pc, input logic [1:0] n);
    pc_add = pc + PC_W'(n);
  endfunction

  // Step back from the operand to the opcode's own address
  function automatic logic [PC_W-1:0] pc_back(input logic [PC_W-1:0] pc);
    pc_back = pc - PC_W'(1'b1);
  endfunction

  // Bank jump opcode class
  function automatic logic is_jmp(input logic [7:0] op);
    is_jmp = (op[7:3] == `NFX_HI_JMP);
  endfunction

  // Bank-0 call opcode class
  function automatic logic is_cal(input logic [7:0] op);
    is_cal = (op[7:3] == `NFX_HI_CAL);
  endfunction

  // Accumulator-bit branch opcode class
  function automatic logic is_bat(input logic [7:0] op);
    is_bat = (op[7:2] == `NFX_HI_BAT);
  endfunction

  // Any opcode that owns a second byte
  function automatic logic is_two_byte(input logic [7:0] op);
    is_two_byte = is_jmp(op) || is_cal(op) || is_bat(op);
  endfunction

  // True when the group of four holding flag n is all zero
  function automatic logic grp_zero(input logic [15:0] f, input logic [3:0] n);
    logic [3:0] g;
    g = f[{n[3:2], 2'b00} +: 4];
    grp_zero = (g == 4'h0);
  endfunction

  // Decode and execute; one cycle for most, second byte read in NFX_OPERAND
  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    op_d = op_q;
    wr_d = wr_q;
    fl_d = fl_q;
    zf_d = zf_q;
    cf_d = cf_q;
    stk_d = '0;
    stk_d.push_pc = stk_q.push_pc;
    done_d = 1'b0;
    op_pc = pc_back(pc_q);
    fl_clr = fl_q;
    fl_clr[rom_data[3:0]] = 1'b0;
    case (state_q)
      NFX_FETCH: begin
        op_d = rom_data;
        pc_d = pc_add(pc_q, 2'd1);
        done_d = 1'b1;
        if (rom_data == `NFX_OP_SWAP_H0) begin
          wr_d.pointer_high_nibble = wr_q.alt_high_reg0;
          wr_d.alt_high_reg0 = wr_q.pointer_high_nibble;
        end else if (rom_data == `NFX_OP_SWAP_H1) begin
          wr_d.pointer_high_nibble = wr_q.alt_high_reg1;
          wr_d.alt_high_reg1 = wr_q.pointer_high_nibble;
        end else if (rom_data == `NFX_OP_SWAP_L0) begin
          wr_d.pointer_low_nibble = wr_q.alt_low_reg0;
          wr_d.alt_low_reg0 = wr_q.pointer_low_nibble;
        end else if (rom_data == `NFX_OP_SWAP_L1) begin
          wr_d.pointer_low_nibble = wr_q.alt_low_reg1;
          wr_d.alt_low_reg1 = wr_q.pointer_low_nibble;
        end else if (rom_data == `NFX_OP_INDIRECT_PAGE_JUMP_OP) begin
          // Hold PC; the page jump lands at the end of the third cycle
          pc_d = pc_q;
          done_d = 1'b0;
          state_d = NFX_WAIT1;
        end else if (rom_data == `NFX_OP_RT) begin
          pc_d = stack_top;
          stk_d.pop = 1'b1;
        end else if (rom_data == `NFX_OP_RTI) begin
          pc_d = stack_top;
          stk_d.pop = 1'b1;
          cf_d = saved_carry_flag;
          zf_d = saved_zero_flag;
        end else if (rom_data[7:4] == `NFX_HI_SETF) begin
          fl_d[rom_data[3:0]] = 1'b1;
        end else if (rom_data[7:4] == `NFX_HI_CLRF) begin
          fl_d = fl_clr;
          zf_d = grp_zero(fl_clr, rom_data[3:0]);
        end else if (rom_data[7:4] == `NFX_HI_CZP) begin
          stk_d.push = 1'b1;
          stk_d.push_pc = pc_add(pc_q, 2'd1);
          pc_d = '0;
          pc_d[5:2] = rom_data[3:0];
        end else if (is_two_byte(rom_data)) begin
          // Operand follows; PC already steps onto it
          done_d = 1'b0;
          state_d = NFX_OPERAND;
        end
      end
      NFX_OPERAND: begin
        // pc_q already points past the opcode, at the operand byte
        state_d = NFX_FETCH;
        done_d = 1'b1;
        pc_d = pc_add(pc_q, 2'd1);
        // Jump bank and branch page come from the opcode address, op_pc; calls use bank 0
        if (is_jmp(op_q)) begin
          pc_d = {op_pc[PC_W-1], op_q[2:0], rom_data};
        end else if (is_cal(op_q)) begin
          stk_d.push = 1'b1;
          stk_d.push_pc = pc_add(pc_q, 2'd1);
          pc_d = {1'b0, op_q[2:0], rom_data};
        end else if (is_bat(op_q) && accumulator_nibble[op_q[1:0]]) begin
          pc_d = {op_pc[PC_W-1:8], rom_data};
        end
        // Untaken branch keeps the step past both bytes
      end
      NFX_WAIT1: begin
        state_d = NFX_WAIT2;
      end
      NFX_WAIT2: begin
        // Extension and accumulator are sampled late, after the opcode settles
        pc_d = {pc_q[PC_W-1:8], ext_nibble, accumulator_nibble};
        state_d = NFX_FETCH;
        done_d = 1'b1;
      end
      default: begin
        state_d = NFX_FETCH;
      end
    endcase
  end

  // Register all state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= NFX_FETCH;
      pc_q <= `NFX_PC_RST;
      op_q <= 8'h00;
      wr_q <= {6{`NFX_NIB_RST}};
      fl_q <= `NFX_FLAGS_RST;
      zf_q <= 1'b0;
      cf_q <= 1'b0;
      stk_q <= '0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      op_q <= op_d;
      wr_q <= wr_d;
      fl_q <= fl_d;
      zf_q <= zf_d;
      cf_q <= cf_d;
      stk_q <= stk_d;
      done_q <= done_d;
    end
  end

  // All outputs come straight from flip-flops
  assign rom_addr = pc_q;
  assign stack_req = stk_q;
  assign wregs = wr_q;
  assign flags = fl_q;
  assign zero_flag = zf_q;
  assign carry_flag = cf_q;
  assign instr_done = done_q;

endmodule
`default_nettype wire

// *** bench/nfx_rom.sv ***
`timescale 1ns/100ps
`default_nettype none
module nfx_rom (
  input wire logic [11:0] addr,
  output logic [7:0] data
);
  logic [7:0] mem [4096];
  // Read without a clock, because the core decodes the byte in the same cycle
  assign data = mem[addr];
endmodule
`default_nettype wire

// *** bench/nfx_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "nfx_cfg.svh"
module nfx_assertions
  import nfx_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] rom_addr,
  input wire logic [7:0] rom_data,
  input wire logic [3:0] accumulator_nibble,
  input wire logic [3:0] ext_nibble,
  input wire logic [11:0] stack_top,
  input wire logic saved_carry_flag,
  input wire logic saved_zero_flag,
  input wire nfx_stack_s stack_req,
  input wire nfx_wregs_s wregs,
  input wire logic [15:0] flags,
  input wire logic zero_flag,
  input wire logic carry_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [1:0] w_q;
  wire logic f = w_q == 2'h0;
  wire logic two = rom_data[7:3] == `NFX_HI_JMP || rom_data[7:3] == `NFX_HI_CAL || rom_data[7:2] == `NFX_HI_BAT;
  wire logic take = accumulator_nibble[rom_data[1:0]];
  // Phase tracker, so operand bytes are never mistaken for opcodes
  always_ff @(posedge clk or posedge rst)
    w_q <= rst ? 2'h0 : !f ? w_q - 2'h1 : two ? 2'h1 : rom_data == `NFX_OP_INDIRECT_PAGE_JUMP_OP ? 2'h2 : 2'h0;
  property p_swap; f && rom_data == `NFX_OP_SWAP_H1 |=> wregs.alt_high_reg1 == $past(wregs.pointer_high_nibble); endproperty
  a_swap: assert property (p_swap) else $error("high swap wrong");
  property p_setf; f && rom_data[7:4] == `NFX_HI_SETF |=> flags[$past(rom_data[3:0])]; endproperty
  a_setf: assert property (p_setf) else $error("flag not set");
  property p_clrf; f && rom_data[7:4] == `NFX_HI_CLRF |=> !flags[$past(rom_data[3:0])]
    && zero_flag == (((flags >> {$past(rom_data[3:2]), 2'b00}) & 16'h000f) == 16'h0000); endproperty
  a_clrf: assert property (p_clrf) else $error("flag clear wrong");
  property p_jmp; f && rom_data[7:3] == `NFX_HI_JMP |=> rom_addr == $past(rom_addr) + 12'h001
    ##1 rom_addr == {$past(rom_addr[11], 2), $past(rom_data[2:0], 2), $past(rom_data)}; endproperty
  a_jmp: assert property (p_jmp) else $error("bank jump wrong");
  property p_indirect_page_jump_op; f && rom_data == `NFX_OP_INDIRECT_PAGE_JUMP_OP |=> $stable(rom_addr) [*2]
    ##1 rom_addr == {$past(rom_addr[11:8]), $past(ext_nibble), $past(accumulator_nibble)}; endproperty
  a_indirect_page_jump_op: assert property (p_indirect_page_jump_op) else $error("page jump wrong");
  property p_czp; f && rom_data[7:4] == `NFX_HI_CZP |=> rom_addr == {6'h00, $past(rom_data[3:0]), 2'b00}
    && stack_req.push && stack_req.push_pc == $past(rom_addr) + 12'h001; endproperty
  a_czp: assert property (p_czp) else $error("zero page call wrong");
  property p_cal; f && rom_data[7:3] == `NFX_HI_CAL |-> ##2 rom_addr == {1'b0, $past(rom_data[2:0], 2), $past(rom_data)}
    && stack_req.push && stack_req.push_pc == $past(rom_addr, 2) + 12'h002; endproperty
  a_cal: assert property (p_cal) else $error("bank call wrong");
  property p_rti; f && rom_data == `NFX_OP_RTI |=> rom_addr == $past(stack_top) && stack_req.pop
    && carry_flag == $past(saved_carry_flag) && zero_flag == $past(saved_zero_flag); endproperty
  a_rti: assert property (p_rti) else $error("interrupt return wrong");
  property p_rt; f && rom_data == `NFX_OP_RT |=> rom_addr == $past(stack_top) && stack_req.pop; endproperty
  a_rt: assert property (p_rt) else $error("subroutine return wrong");
  property p_bat; f && rom_data[7:2] == `NFX_HI_BAT |-> ##2
    rom_addr == ($past(take, 2) ? {$past(rom_addr[11:8], 2), $past(rom_data)} : $past(rom_addr, 2) + 12'h002); endproperty
  a_bat: assert property (p_bat) else $error("bit branch wrong");
  c_indirect_page_jump_op: cover property (f && rom_data == `NFX_OP_INDIRECT_PAGE_JUMP_OP);
  c_push: cover property (stack_req.push);
  c_pop: cover property (stack_req.pop);
endmodule
bind nfx_core nfx_assertions i_chk (.clk, .rst, .rom_addr, .rom_data, .accumulator_nibble, .ext_nibble, .stack_top,
  .saved_carry_flag, .saved_zero_flag, .stack_req, .wregs, .flags, .zero_flag, .carry_flag);
`default_nettype wire

// *** bench/nibble_cpu_flow_and_exchange_ops_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module nibble_cpu_flow_and_exchange_ops_bench;
  logic clk = 1'b0, rst = 1'b1, sc = 1'b0, sz = 1'b0, zf = 1'b0, cf = 1'b0, zf_o, cf_o, done;
  logic [3:0] acc = 4'h0, ext = 4'h0, w [6] = '{default: 4'h0};
  logic [11:0] stk = 12'h000, rom_addr, pc = 12'h000, q, pp = 12'h000;
  logic [7:0] rom_data, o, e;
  logic [15:0] flags, fl = 16'h0000;
  logic [31:0] r;
  logic [7:0] ops [14] = '{8'hf8, 8'hfc, 8'hf9, 8'hfd, 8'h50, 8'h10, 8'h68, 8'hfa, 8'hb0, 8'h28, 8'h62, 8'h22, 8'h70, 8'h00};
  logic [7:0] msk [14] = '{0, 0, 0, 0, 15, 15, 7, 0, 15, 7, 0, 0, 3, 0};
  nfx_pkg::nfx_stack_s sreq;
  nfx_pkg::nfx_wregs_s wr;
  int errors = 0, n_compared = 0, seed = 26134, k, c, cy;
  always #20 clk = ~clk;
  nfx_core i_nfx_core (.clk, .rst, .rom_addr, .rom_data, .accumulator_nibble(acc), .ext_nibble(ext), .stack_top(stk),
    .saved_carry_flag(sc), .saved_zero_flag(sz), .stack_req(sreq), .wregs(wr), .flags, .zero_flag(zf_o),
    .carry_flag(cf_o), .instr_done(done));
  nfx_rom i_nfx_rom (.addr(rom_addr), .data(rom_data));
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic close_out;
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Random program laid down just ahead of the fetch; the model runs one instruction per pass
  initial begin
    repeat (4) @(posedge clk);
    #1;
    for (int i = 0; i < 400; i++) begin
      r = $random(seed);
      k = r[31:28] % 14;
      o = ops[k] | (r[7:0] & msk[k]);
      e = r[23:16];
      {acc, ext, stk, sc, sz} = 22'($random(seed));
      i_nfx_rom.mem[pc] = o;
      i_nfx_rom.mem[pc + 12'h001] = e;
      q = pc;
      pc = q + 12'h001;
      cy = 1;
      case (k)
        0, 1, 2, 3: {w[k / 2], w[k + 2]} = {w[k + 2], w[k / 2]};
        4: fl[o[3:0]] = 1'b1;
        5: begin fl[o[3:0]] = 1'b0; zf = ((fl >> {o[3:2], 2'b00}) & 16'h000f) == 16'h0000; end
        6: begin cy = 2; pc = {q[11], o[2:0], e}; end
        7: begin cy = 3; pc = {q[11:8], ext, acc}; end
        8: begin pp = q + 12'h001; pc = {6'h00, o[3:0], 2'b00}; end
        9: begin cy = 2; pp = q + 12'h002; pc = {1'b0, o[2:0], e}; end
        10, 11: begin pc = stk; if (k == 11) {cf, zf} = {sc, sz}; end
        12: begin cy = 2; pc = acc[o[1:0]] ? {q[11:8], e} : q + 12'h002; end
        default: ;
      endcase
      if (i == 0) rst = 1'b0;
      c = 0;
      do begin @(posedge clk); #1; c++; end while (done !== 1'b1 && c < 8);
      if (done !== 1'b1) begin errors++; close_out; end
      chk(c, cy);
      chk(rom_addr, pc);
      chk(wr, {w[0], w[1], w[2], w[3], w[4], w[5]});
      chk(flags, fl);
      chk({zf_o, cf_o}, {zf, cf});
      chk({sreq.push, sreq.pop, sreq.push_pc}, {k == 8 || k == 9, k == 10 || k == 11, pp});
    end
    close_out;
  end
endmodule
`default_nettype wire
